// *** design/sbg_top.sv ***
// Brake timing, electronic gear, encoder output settings with APB slave.
module sbg_top #(
	parameter int MS_CYC = sbg_pkg::MS_CYCLES
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_b,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive status inputs.
	input wire logic servo_on,
	input wire logic pulse_position_mode,
	input wire logic fault_active,
	input wire logic excluded_fault_alarm,
	input wire logic emergency_stop_input,
	input wire logic encoder_fault,
	// Speeds in r/min, signed.
	input wire logic signed [15:0] motor_speed,
	input wire logic signed [15:0] speed_command,
	input wire logic signed [15:0] feedback_speed,
	// Pulses.
	input wire logic cmd_pulse_in,
	output logic pos_cmd_pulse,
	// Outputs to motor side.
	output logic brake_release_output,
	output logic zero_speed_output,
	output logic speed_reached_output,
	output logic encoder_output_error_alarm,
	output logic [31:0] encoder_out_count_setting
);

	////////////////////////////////////////////////////////////////////////
	// Whole state of the block.
	typedef struct packed {
		logic [15:0] on_dly;
		logic [15:0] off_dly;
		logic [31:0] num1;
		logic [31:0] num2;
		logic [31:0] num3;
		logic [31:0] num4;
		logic [31:0] den;
		logic [31:0] ppr;
		logic [15:0] spd_rng;
		logic [15:0] zero_rng;
		logic [15:0] enc_lim;
		logic [1:0] num_sel;
		sbg_pkg::sbg_brk_state_t brk;
		logic [31:0] tick;
		logic [15:0] ms;
		logic [15:0] wait_ms;
		logic prev_on;
		logic brake;
		logic zero;
		logic speed_reached_range_setting;
		logic enc_err;
		logic reject;
		logic [31:0] rdata;
	} sbg_st_t;

	sbg_st_t s_q, s_d;

	// Decoded bus access.
	logic acc_wr;
	logic [11:0] idx;
	logic mapped;
	// Magnitudes of speeds.
	logic [15:0] spd_abs;
	logic [16:0] err_abs;
	logic [16:0] err_raw;
	// Selected numerator.
	logic [31:0] num_act;

	////////////////////////////////////////////////////////////////////////
	// Bus decode: word index is the byte address over four.
	always_comb begin
		idx = paddr[13:2];
		acc_wr = psel && penable && pwrite;
		case (idx)
			sbg_pkg::IDX_BRAKE_ON, sbg_pkg::IDX_BRAKE_OFF,
			sbg_pkg::IDX_GEAR_NUM, sbg_pkg::IDX_GEAR_DEN,
			sbg_pkg::IDX_ENC_PPR, sbg_pkg::IDX_SPD_RANGE,
			sbg_pkg::IDX_GEAR_NUM2, sbg_pkg::IDX_GEAR_NUM3,
			sbg_pkg::IDX_GEAR_NUM4, sbg_pkg::IDX_ZERO_SPD,
			sbg_pkg::IDX_ENC_SPD_LIM, sbg_pkg::IDX_CTRL,
			sbg_pkg::IDX_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Speed magnitudes for the comparators.
	always_comb begin
		spd_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
		err_raw = 17'({speed_command[15], speed_command}
			- {feedback_speed[15], feedback_speed});
		err_abs = err_raw[16] ? 17'(-err_raw) : err_raw;
	end

	// Numerator chosen by the selection field.
	always_comb begin
		case (s_q.num_sel)
			2'h1: num_act = s_q.num2;
			2'h2: num_act = s_q.num3;
			2'h3: num_act = s_q.num4;
			default: num_act = s_q.num1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: registers, brake sequencer and speed flags.
	always_comb begin
		logic signed [15:0] offs;
		offs = '0;
		s_d = s_q;
		s_d.reject = 1'b0;
		s_d.prev_on = servo_on;

		// Register writes; out-of-range brake-on and encoder values ignored.
		if (acc_wr) begin
			case (idx)
				sbg_pkg::IDX_BRAKE_ON: begin
					if (pwdata[15:0] <= sbg_pkg::BRAKE_DLY_MAX) begin
						s_d.on_dly = pwdata[15:0];
					end
				end
				sbg_pkg::IDX_BRAKE_OFF: s_d.off_dly = pwdata[15:0];
				sbg_pkg::IDX_GEAR_NUM: begin
					if (pulse_position_mode && !servo_on) begin
						s_d.reject = 1'b1;
					end else begin
						s_d.num1 = pwdata;
					end
				end
				sbg_pkg::IDX_GEAR_DEN: begin
					if (pulse_position_mode && servo_on) begin
						s_d.reject = 1'b1;
					end else begin
						s_d.den = pwdata;
					end
				end
				sbg_pkg::IDX_ENC_PPR: begin
					if (pwdata >= sbg_pkg::ENC_PPR_MIN
						&& pwdata <= sbg_pkg::ENC_PPR_MAX) begin
						s_d.ppr = pwdata;
					end
				end
				sbg_pkg::IDX_SPD_RANGE: s_d.spd_rng = pwdata[15:0];
				sbg_pkg::IDX_GEAR_NUM2: s_d.num2 = pwdata;
				sbg_pkg::IDX_GEAR_NUM3: s_d.num3 = pwdata;
				sbg_pkg::IDX_GEAR_NUM4: s_d.num4 = pwdata;
				sbg_pkg::IDX_ZERO_SPD: s_d.zero_rng = pwdata[15:0];
				sbg_pkg::IDX_ENC_SPD_LIM: s_d.enc_lim = pwdata[15:0];
				sbg_pkg::IDX_CTRL: begin
					s_d.num_sel = pwdata[sbg_pkg::CTRL_NUM_SEL_HI:
						sbg_pkg::CTRL_NUM_SEL_LO];
				end
				default: begin
				end
			endcase
		end

		// Millisecond tick counter, restarted whenever a wait begins.
		if (s_q.tick == 32'(MS_CYC - 1)) begin
			s_d.tick = '0;
			s_d.ms = s_q.ms + 16'h0001;
		end else begin
			s_d.tick = s_q.tick + 32'h00000001;
		end

		// Brake sequencer.
		case (s_q.brk)
			sbg_pkg::BRK_IDLE: begin
				s_d.brake = 1'b0;
				if (servo_on && !s_q.prev_on) begin
					s_d.brk = sbg_pkg::BRK_ON_WAIT;
					s_d.wait_ms = s_q.on_dly;
					s_d.tick = '0;
					s_d.ms = '0;
				end
			end
			sbg_pkg::BRK_ON_WAIT: begin
				if (!servo_on) begin
					s_d.brk = sbg_pkg::BRK_IDLE;
				end else if (s_q.ms >= s_q.wait_ms) begin
					s_d.brake = 1'b1;
					s_d.brk = sbg_pkg::BRK_RELEASED;
				end
			end
			sbg_pkg::BRK_RELEASED: begin
				if (!servo_on) begin
					offs = s_q.off_dly;
					// Fault or estop stops at once for negative delays.
					if ((fault_active && !excluded_fault_alarm)
						|| emergency_stop_input) begin
						if (offs[15]) begin
							offs = '0;
						end
					end
					// A negative delay engages the brake at disable.
					if (offs[15] || offs == 16'sh0000) begin
						s_d.brake = 1'b0;
						s_d.brk = sbg_pkg::BRK_IDLE;
					end else begin
						s_d.brk = sbg_pkg::BRK_OFF_WAIT;
						s_d.wait_ms = offs;
						s_d.tick = '0;
						s_d.ms = '0;
					end
				end
			end
			sbg_pkg::BRK_OFF_WAIT: begin
				// Re-enable during the wait keeps the brake open; falling
				// back to idle would need a fresh enable edge and leave
				// a running motor against a closed brake.
				if (servo_on) begin
					s_d.brk = sbg_pkg::BRK_RELEASED;
				end else if (s_q.zero) begin
					s_d.brake = 1'b0;
					s_d.brk = sbg_pkg::BRK_IDLE;
				end else if (s_q.ms >= s_q.wait_ms) begin
					s_d.brake = 1'b0;
					s_d.brk = sbg_pkg::BRK_IDLE;
				end
			end
			default: begin
				s_d.brk = sbg_pkg::BRK_IDLE;
				s_d.brake = 1'b0;
			end
		endcase

		// Speed flags, registered so outputs come from flip-flops.
		s_d.zero = (spd_abs <= s_q.zero_rng);
		s_d.speed_reached_range_setting = (s_q.spd_rng != 16'h0000)
			&& (err_abs <= {1'b0, s_q.spd_rng});
		s_d.enc_err = encoder_fault || (spd_abs > s_q.enc_lim);

		// Read data latched in the setup cycle.
		s_d.rdata = '0;
		case (idx)
			sbg_pkg::IDX_BRAKE_ON: s_d.rdata = {16'h0000, s_q.on_dly};
			sbg_pkg::IDX_BRAKE_OFF: s_d.rdata = {16'h0000, s_q.off_dly};
			sbg_pkg::IDX_GEAR_NUM: s_d.rdata = s_q.num1;
			sbg_pkg::IDX_GEAR_DEN: s_d.rdata = s_q.den;
			sbg_pkg::IDX_ENC_PPR: s_d.rdata = s_q.ppr;
			sbg_pkg::IDX_SPD_RANGE: s_d.rdata = {16'h0000, s_q.spd_rng};
			sbg_pkg::IDX_GEAR_NUM2: s_d.rdata = s_q.num2;
			sbg_pkg::IDX_GEAR_NUM3: s_d.rdata = s_q.num3;
			sbg_pkg::IDX_GEAR_NUM4: s_d.rdata = s_q.num4;
			sbg_pkg::IDX_ZERO_SPD: s_d.rdata = {16'h0000, s_q.zero_rng};
			sbg_pkg::IDX_ENC_SPD_LIM: s_d.rdata = {16'h0000, s_q.enc_lim};
			sbg_pkg::IDX_CTRL: s_d.rdata = {30'h00000000, s_q.num_sel};
			sbg_pkg::IDX_STATUS: begin
				s_d.rdata = {27'h0000000, s_q.reject, s_q.enc_err,
					s_q.speed_reached_range_setting, s_q.zero, s_q.brake};
			end
			default: s_d.rdata = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register the whole state.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.on_dly <= sbg_pkg::RST_BRAKE_ON;
			s_q.off_dly <= sbg_pkg::RST_BRAKE_OFF;
			s_q.num1 <= sbg_pkg::RST_GEAR_NUM;
			s_q.num2 <= sbg_pkg::RST_GEAR_NUM;
			s_q.num3 <= sbg_pkg::RST_GEAR_NUM;
			s_q.num4 <= sbg_pkg::RST_GEAR_NUM;
			s_q.den <= sbg_pkg::RST_GEAR_DEN;
			s_q.ppr <= sbg_pkg::RST_ENC_PPR;
			s_q.spd_rng <= sbg_pkg::RST_SPD_RANGE;
			s_q.zero_rng <= sbg_pkg::RST_ZERO_SPD;
			s_q.enc_lim <= sbg_pkg::RST_ENC_SPD_LIM;
			s_q.brk <= sbg_pkg::BRK_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gear scaler for the command pulse stream.
	sbg_gear u_gear (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.num(num_act),
		.den(s_q.den),
		.pulse_in(cmd_pulse_in),
		.pulse_out(pos_cmd_pulse)
	);

	// Bus answer: zero wait states, error on unmapped index.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = s_q.rdata;

	// Outputs.
	assign brake_release_output = s_q.brake;
	assign zero_speed_output = s_q.zero;
	assign speed_reached_output = s_q.speed_reached_range_setting;
	assign encoder_output_error_alarm = s_q.enc_err;
	assign encoder_out_count_setting = s_q.ppr;

endmodule : sbg_top

// *** design/sbg_pkg.sv ***
// Package with register map, reset values and timing constants of the brake/gear block.
package sbg_pkg;

	// Printed offsets are not all word multiples, so they are indices.
	localparam logic [11:0] IDX_BRAKE_ON = 12'h154;
	localparam logic [11:0] IDX_BRAKE_OFF = 12'h156;
	localparam logic [11:0] IDX_GEAR_NUM = 12'h158;
	localparam logic [11:0] IDX_GEAR_DEN = 12'h15a;
	localparam logic [11:0] IDX_ENC_PPR = 12'h15c;
	localparam logic [11:0] IDX_SPD_RANGE = 12'h15e;
	// Extra registers for the additional numerators, speed settings, control and status.
	localparam logic [11:0] IDX_GEAR_NUM2 = 12'h200;
	localparam logic [11:0] IDX_GEAR_NUM3 = 12'h201;
	localparam logic [11:0] IDX_GEAR_NUM4 = 12'h202;
	localparam logic [11:0] IDX_ZERO_SPD = 12'h203;
	localparam logic [11:0] IDX_ENC_SPD_LIM = 12'h204;
	localparam logic [11:0] IDX_CTRL = 12'h205;
	localparam logic [11:0] IDX_STATUS = 12'h206;

	// Reset values.
	localparam logic [15:0] RST_BRAKE_ON = 16'h0000;
	localparam logic [15:0] RST_BRAKE_OFF = 16'h0000;
	localparam logic [31:0] RST_GEAR_NUM = 32'h00000010;
	localparam logic [31:0] RST_GEAR_DEN = 32'h0000000a;
	localparam logic [31:0] RST_ENC_PPR = 32'h000009c4;
	localparam logic [15:0] RST_SPD_RANGE = 16'h000a;
	localparam logic [15:0] RST_ZERO_SPD = 16'h0064;
	localparam logic [15:0] RST_ENC_SPD_LIM = 16'h1388;

	// Field limits.
	localparam logic [15:0] BRAKE_DLY_MAX = 16'h03e8;
	localparam logic [31:0] ENC_PPR_MIN = 32'h00000004;
	localparam logic [31:0] ENC_PPR_MAX = 32'h00009c40;

	// Control register bit positions.
	localparam int CTRL_NUM_SEL_LO = 0;
	localparam int CTRL_NUM_SEL_HI = 1;

	// Status register bit positions.
	localparam int ST_BRAKE = 0;
	localparam int ST_ZERO = 1;
	localparam int ST_SPEED_REACHED_RANGE_SETTING = 2;
	localparam int ST_ENC_ERR = 3;
	localparam int ST_REJECT = 4;

	// Timing: one millisecond tick at 200 MHz.
	localparam int CLK_MHZ = 200;
	localparam int MS_US = 1000;
	localparam int MS_CYCLES = CLK_MHZ * MS_US;

	// Brake sequencing states.
	typedef enum logic [1:0] {
		BRK_IDLE,
		BRK_ON_WAIT,
		BRK_RELEASED,
		BRK_OFF_WAIT
	} sbg_brk_state_t;

endpackage : sbg_pkg

// *** design/sbg_gear.sv ***
// Pulse gear scaler: input pulses times numerator over denominator.
module sbg_gear (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_b,
	// Gear ratio.
	input wire logic [31:0] num,
	input wire logic [31:0] den,
	// Pulse stream.
	input wire logic pulse_in,
	output logic pulse_out
);

	////////////////////////////////////////////////////////////////////////
	// State: residue accumulator and the registered output pulse.
	typedef struct packed {
		logic [32:0] acc;
		logic out;
	} sbg_gear_st_t;

	sbg_gear_st_t s_q, s_d;

	////////////////////////////////////////////////////////////////////////
	// Each input pulse adds num to the residue; one output pulse per cycle
	// is issued while the residue holds a whole denominator. This caps the
	// output at the clock rate, which is far above any motor pulse rate.
	always_comb begin
		s_d = s_q;
		s_d.out = 1'b0;
		if (pulse_in) begin
			s_d.acc = s_q.acc + {1'b0, num};
		end
		if (den != 32'h00000000 && s_d.acc >= {1'b0, den}) begin
			s_d.acc = s_d.acc - {1'b0, den};
			s_d.out = 1'b1;
		end
	end

	// Register the state.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse_out = s_q.out;

endmodule : sbg_gear

// *** test/sbg_props.sv ***
// Concurrent checks on the ports of the brake/gear block.
module sbg_props #(
	parameter int MS_CYC = 10
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_b,
	// Drive inputs.
	input wire logic servo_on,
	input wire logic encoder_fault,
	input wire logic signed [15:0] motor_speed,
	// Outputs watched.
	input wire logic brake_release_output,
	input wire logic zero_speed_output,
	input wire logic encoder_output_error_alarm,
	input wire logic [31:0] encoder_out_count_setting,
	input wire logic pos_cmd_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Speed magnitude; the bench keeps the range setting at its reset value.
	logic [15:0] spd_abs;
	logic zs_exp;
	assign spd_abs = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
	assign zs_exp = spd_abs <= sbg_pkg::RST_ZERO_SPD;

	// Cycles spent disabled, saturating so it never wraps to zero.
	logic [31:0] off_cnt_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			off_cnt_q <= 32'h0;
		end else if (servo_on) begin
			off_cnt_q <= 32'h0;
		end else if (off_cnt_q != 32'hffffffff) begin
			off_cnt_q <= off_cnt_q + 32'h1;
		end
	end

	////////////////////////////////////////
	// The brake only opens after the drive has been enabled.
	property p_rel_on;
		$rose(brake_release_output) |-> $past(servo_on);
	endproperty
	a_rel_on: assert property (p_rel_on)
		else $error("release while disabled");
	// Enable never opens the brake in the very next cycle.
	property p_no_instant;
		$rose(servo_on) && !brake_release_output |=> !brake_release_output;
	endproperty
	a_no_instant: assert property (p_no_instant)
		else $error("release too early");
	// Zero speed while disabled engages the brake within a few cycles.
	property p_zero_eng;
		!servo_on && zero_speed_output |-> ##[1:4] !brake_release_output;
	endproperty
	a_zero_eng: assert property (p_zero_eng)
		else $error("zero speed kept brake open");
	// The flag follows speed one cycle late; the edge that releases reset
	// is skipped, since the flag was still held low at that edge.
	property p_zflag;
		rst_b |=> zero_speed_output == $past(zs_exp);
	endproperty
	a_zflag: assert property (p_zflag)
		else $error("zero speed flag wrong");
	// An encoder fault raises the alarm one cycle later.
	property p_enc_flt;
		encoder_fault |=> encoder_output_error_alarm;
	endproperty
	a_enc_flt: assert property (p_enc_flt)
		else $error("no alarm on encoder fault");
	// Overspeed against the default limit raises the alarm too.
	property p_enc_spd;
		spd_abs > sbg_pkg::RST_ENC_SPD_LIM |=> encoder_output_error_alarm;
	endproperty
	a_enc_spd: assert property (p_enc_spd)
		else $error("no alarm on overspeed");
	// The pulse count never leaves its legal range.
	property p_ppr;
		encoder_out_count_setting >= sbg_pkg::ENC_PPR_MIN
			&& encoder_out_count_setting <= sbg_pkg::ENC_PPR_MAX;
	endproperty
	a_ppr: assert property (p_ppr)
		else $error("pulse count out of range");
	// An off delay up to 1000 ms never keeps the brake open beyond 1000 ms plus 4 cycles after disable.
	property p_off_bnd;
		off_cnt_q > 1000 * MS_CYC + 4 |-> !brake_release_output;
	endproperty
	a_off_bnd: assert property (p_off_bnd)
		else $error("brake open too long");
	// Main scenarios: release, geared pulses, alarm.
	c_rel: cover property ($rose(brake_release_output));
	c_gear: cover property (pos_cmd_pulse);
	c_alarm: cover property ($rose(encoder_output_error_alarm));
endmodule : sbg_props

// Attach the checker to every instance of the block.
bind sbg_top sbg_props #(.MS_CYC(MS_CYC)) u_props (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.servo_on(servo_on),
	.encoder_fault(encoder_fault),
	.motor_speed(motor_speed),
	.brake_release_output(brake_release_output),
	.zero_speed_output(zero_speed_output),
	.encoder_output_error_alarm(encoder_output_error_alarm),
	.encoder_out_count_setting(encoder_out_count_setting),
	.pos_cmd_pulse(pos_cmd_pulse)
);

// *** test/sbg_host.sv ***
// Model of the host controller that enables the drive and sends pulses.
module sbg_host (
	// Clock.
	input wire logic core_clk,
	// Command outputs.
	output logic servo_on,
	output logic cmd_pulse_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle at time zero: disabled, no pulse.
	initial begin
		servo_on = 1'b0;
		cmd_pulse_in = 1'b0;
	end

	// Changes the enable level right after a rising edge.
	task automatic set_on(input logic v);
		@(posedge core_clk);
		servo_on <= v;
	endtask : set_on

	// One-cycle pulses; a larger gap models a slow host.
	task automatic pulses(input int n, input int gap);
		repeat (n) begin
			@(posedge core_clk);
			cmd_pulse_in <= 1'b1;
			@(posedge core_clk);
			cmd_pulse_in <= 1'b0;
			repeat (gap) @(posedge core_clk);
		end
	endtask : pulses
endmodule : sbg_host

// *** test/sbg_tb_top.sv ***
// Self-checking bench of the brake/gear block.
module sbg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSC = 10;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel, penable, pwrite;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd, ppr;
	logic pready, pslverr, err, servo_on, cmd_pulse_in, pos_cmd_pulse;
	logic pulse_position_mode, fault_active, encoder_fault;
	logic excluded_fault_alarm, emergency_stop_input;
	logic signed [15:0] motor_speed, speed_command;
	logic signed [15:0] feedback_speed;
	logic brk, zero, speed_reached_range_setting, alarm;
	int n_mismatch = 0, num_checks = 0, n_out = 0;

	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (pos_cmd_pulse === 1'b1) n_out++;

	sbg_top #(.MS_CYC(MSC)) uut (.core_clk, .rst_b, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .servo_on,
		.pulse_position_mode, .fault_active, .excluded_fault_alarm,
		.emergency_stop_input, .encoder_fault, .motor_speed, .speed_command,
		.feedback_speed, .cmd_pulse_in, .pos_cmd_pulse,
		.brake_release_output(brk), .zero_speed_output(zero),
		.speed_reached_output(speed_reached_range_setting), .encoder_output_error_alarm(alarm),
		.encoder_out_count_setting(ppr));
	sbg_host host (.core_clk, .servo_on, .cmd_pulse_in);

	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; read data and error are taken at the ready edge.
	// Only the watchdog ends a wait for ready.
	task automatic apb(input logic wr, input logic [11:0] idx,
		input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Brake keeps the other level for lo cycles, then reaches v within hi.
	task automatic wbrk(input logic v, input int lo, input int hi);
		int bad;
		int i;
		bad = 0;
		i = 0;
		repeat (lo) begin
			@(negedge core_clk);
			if (brk !== ~v) bad++;
		end
		chk(bad, 0);
		while (brk !== v && i < hi) begin
			@(negedge core_clk);
			i++;
		end
		chk(brk, v);
	endtask : wbrk

	// Applies speeds and encoder fault, lets the flags settle.
	task automatic spd(input logic [15:0] m, input logic [15:0] c, input logic [15:0] f, input logic ef);
		@(posedge core_clk);
		motor_speed <= m;
		speed_command <= c;
		feedback_speed <= f;
		encoder_fault <= ef;
		repeat (3) @(negedge core_clk);
	endtask : spd

	task automatic summarize;
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// A hang is cut short well past the expected run length.
	initial begin
		#200us;
		n_mismatch++;
		summarize();
	end

	initial begin
		logic [11:0] ri[6] = '{sbg_pkg::IDX_BRAKE_ON, sbg_pkg::IDX_BRAKE_OFF, sbg_pkg::IDX_GEAR_NUM, sbg_pkg::IDX_GEAR_DEN, sbg_pkg::IDX_ENC_PPR, sbg_pkg::IDX_SPD_RANGE};
		logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h10, 32'ha, 32'h9c4, 32'ha};
		logic [31:0] pw[4] = '{32'h3, 32'h9c40, 32'h9c41, 32'h4};
		logic [31:0] pe[4] = '{32'h9c4, 32'h9c40, 32'h9c40, 32'h4};
		// Idle bus and quiet drive inputs while reset is held.
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 14'h0;
		pwdata <= 32'h0;
		pulse_position_mode <= 1'b0;
		fault_active <= 1'b0;
		encoder_fault <= 1'b0;
		excluded_fault_alarm <= 1'b0;
		emergency_stop_input <= 1'b0;
		motor_speed <= 16'sh0;
		speed_command <= 16'sh0;
		feedback_speed <= 16'sh0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ri[i], 32'h0);
			chk(rd, rv[i]);
		end
		apb(1'b0, 12'h100, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, sbg_pkg::IDX_ENC_PPR, pw[i]);
			@(negedge core_clk);
			chk(ppr, pe[i]);
		end
		// Gear locks in pulse-position mode, disabled then enabled.
		@(posedge core_clk);
		pulse_position_mode <= 1'b1;
		apb(1'b1, sbg_pkg::IDX_GEAR_NUM, 32'h20);
		apb(1'b0, sbg_pkg::IDX_GEAR_NUM, 32'h0);
		chk(rd, 32'h10);
		apb(1'b1, sbg_pkg::IDX_GEAR_DEN, 32'h14);
		apb(1'b0, sbg_pkg::IDX_GEAR_DEN, 32'h0);
		chk(rd, 32'h14);
		host.set_on(1'b1);
		apb(1'b1, sbg_pkg::IDX_GEAR_NUM, 32'h20);
		apb(1'b0, sbg_pkg::IDX_GEAR_NUM, 32'h0);
		chk(rd, 32'h20);
		apb(1'b1, sbg_pkg::IDX_GEAR_DEN, 32'h5);
		apb(1'b0, sbg_pkg::IDX_GEAR_DEN, 32'h0);
		chk(rd, 32'h14);
		// Ratio 32/20 stays inside the legal window; 10 pulses give 16.
		n_out = 0;
		host.pulses(10, 2);
		repeat (10) @(posedge core_clk);
		chk(n_out, 16);
		// Second numerator 40 over 20 doubles the pulse count.
		apb(1'b1, sbg_pkg::IDX_GEAR_NUM2, 32'h28);
		apb(1'b1, sbg_pkg::IDX_CTRL, 32'h1);
		n_out = 0;
		host.pulses(10, 2);
		repeat (10) @(posedge core_clk);
		chk(n_out, 20);
		apb(1'b1, sbg_pkg::IDX_CTRL, 32'h0);
		host.set_on(1'b0);
		apb(1'b1, sbg_pkg::IDX_BRAKE_ON, 32'h3e9);
		apb(1'b0, sbg_pkg::IDX_BRAKE_ON, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, sbg_pkg::IDX_BRAKE_ON, 32'h3);
		apb(1'b1, sbg_pkg::IDX_BRAKE_OFF, 32'h5);
		spd(16'd1000, 16'h0, 16'h0, 1'b0);
		host.set_on(1'b1);
		wbrk(1'b1, 3 * MSC - 2, 10);
		host.set_on(1'b0);
		wbrk(1'b0, 5 * MSC - 5, 12);
		host.set_on(1'b1);
		wbrk(1'b1, 3 * MSC - 2, 10);
		host.set_on(1'b0);
		repeat (10) @(negedge core_clk);
		chk(brk, 1'b1);
		spd(16'd0, 16'h0, 16'h0, 1'b0);
		chk(brk, 1'b0);
		// Negative off delay: normal, fault, emergency and excluded stops.
		apb(1'b1, sbg_pkg::IDX_BRAKE_OFF, 32'hfffb);
		spd(16'd1000, 16'h0, 16'h0, 1'b0);
		for (int c = 0; c < 4; c++) begin
			host.set_on(1'b1);
			wbrk(1'b1, 3 * MSC - 2, 10);
			@(posedge core_clk);
			fault_active <= (c == 1 || c == 3);
			excluded_fault_alarm <= (c == 3);
			emergency_stop_input <= (c == 2);
			host.set_on(1'b0);
			wbrk(1'b0, 0, 3);
			@(posedge core_clk);
			fault_active <= 1'b0;
			excluded_fault_alarm <= 1'b0;
			emergency_stop_input <= 1'b0;
		end
		spd(16'd101, 16'd500, 16'd510, 1'b0);
		chk({zero, speed_reached_range_setting}, 2'b01);
		spd(-16'sd100, 16'd500, 16'd511, 1'b0);
		chk({zero, speed_reached_range_setting}, 2'b10);
		spd(16'd5001, 16'd0, 16'd0, 1'b0);
		chk(alarm, 1'b1);
		spd(16'd5000, 16'd0, 16'd0, 1'b1);
		chk(alarm, 1'b1);
		spd(16'd5000, 16'd0, 16'd0, 1'b0);
		chk(alarm, 1'b0);
		apb(1'b1, sbg_pkg::IDX_SPD_RANGE, 32'h0);
		spd(16'd0, 16'd7, 16'd7, 1'b0);
		chk(speed_reached_range_setting, 1'b0);
		summarize();
	end
endmodule : sbg_tb_top
